// ### design/adc_control_and_result_regs.v
// The implementer's own choice: register access over APB.
`include "adc_defs.vh"

module adc_control_and_result_regs (
  // System
  input  wire        clock,
  input  wire        nrst,
  // Low power status from the core
  input  wire        haltMode,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Interrupt
  output wire        irq,
  // Analog multiplexer and converter core
  input  wire        compareIn,
  output wire [3:0]  channelSelect,
  output wire        muxEnable,
  output wire        sampleEnable,
  output wire [9:0]  trialCode,
  output wire        converterPowerDown
);

  localparam ST_IDLE   = `ADC_ST_IDLE;
  localparam ST_SAMPLE = `ADC_ST_SAMPLE;
  localparam ST_SETTLE = `ADC_ST_SETTLE;
  localparam ST_DECIDE = `ADC_ST_DECIDE;

  // Bus state
  reg        pready_r;
  reg        pslverr_r;
  reg [31:0] prdata_r;
  reg [1:0]  capStat_r;
  reg        freshResult_r;

  // Software-visible state
  reg        done_r;
  reg        speed_r;
  reg        convOn_r;
  reg [3:0]  channel_r;
  reg [9:0]  result_r;
  reg [1:0]  evtStat_r;
  reg [1:0]  evtMask_r;
  reg        irq_r;

  // Sequencer
  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg [1:0]  divCnt_r;
  reg [3:0]  tickCnt_r;
  reg [9:0]  trialBit_r;
  reg [9:0]  code_r;
  reg        sample_r;
  reg        powerDown_r;
  reg        muxEn_r;
  reg [3:0]  chanOut_r;

  // Comparator synchroniser
  reg        cmpS1_r;
  reg        cmpS2_r;
  reg        cmpS3_r;
  reg        cmpStable_r;

  reg [7:0]  readByte;
  reg [9:0]  codeKept;

  // Address decode
  wire [9:0] regIndex = paddr[11:2];
  wire       selCsr   = (regIndex == `ADC_IDX_CSR);
  wire       selHigh  = (regIndex == `ADC_IDX_HIGH);
  wire       selLow   = (regIndex == `ADC_IDX_LOW);
  wire       selStat  = (regIndex == `ADC_IDX_EVT_STAT);
  wire       selMask  = (regIndex == `ADC_IDX_EVT_MASK);
  wire       mapped   = selCsr | selHigh | selLow | selStat | selMask;

  // A transfer completes at the second access-phase edge
  wire       apbAccess = psel & penable;
  wire       apbFirst  = apbAccess & ~pready_r;
  wire       apbDone   = apbAccess & pready_r;
  wire       wrCsr     = apbDone & pwrite & selCsr & pstrb[0];
  wire       wrMask    = apbDone & pwrite & selMask & pstrb[0];
  wire       rdHigh    = apbDone & ~pwrite & selHigh;
  wire       rdStat    = apbDone & ~pwrite & selStat;

  // Converter enable after this edge; halt overrides the software bit
  wire       onNxt     = wrCsr ? pwdata[`ADC_CSR_ON_BIT] : convOn_r;
  wire       runNxt    = onNxt & ~haltMode;                              // see R01, R03
  wire       chanNew   = wrCsr & (pwdata[`ADC_CSR_CH_MSB:`ADC_CSR_CH_LSB] != channel_r);
  wire       running   = (state_r != ST_IDLE);
  wire       abortConv = running & (~runNxt | chanNew);                  // see R15

  // Conversion clock tick
  wire [1:0] divLast   = speed_r ? `ADC_DIV2_LAST : `ADC_DIV4_LAST;      // see R05
  wire       tick      = running & (divCnt_r == divLast);

  wire       finish    = (state_r == ST_DECIDE) & tick & trialBit_r[0] & ~abortConv;

  // Done flag: completion wins over a clearing access in the same cycle
  wire       doneClr   = wrCsr | (rdHigh & ~freshResult_r);              // see R04
  wire       doneNxt   = finish | (done_r & ~doneClr);                   // see R04

  // Event status: read clears only what the read returned
  wire [1:0] evtSet;
  assign evtSet[`ADC_EVT_DONE_BIT] = finish;
  assign evtSet[`ADC_EVT_OVR_BIT]  = finish & done_r & ~doneClr;
  wire [1:0] evtClr    = rdStat ? capStat_r : 2'h0;
  wire [1:0] evtNxt    = evtSet | (evtStat_r & ~evtClr);
  wire [1:0] maskNxt   = wrMask ? pwdata[1:0] : evtMask_r;

  // Read multiplexer
  always @* begin
    readByte = 8'h00;
    if (selCsr) begin
      readByte[`ADC_CSR_DONE_BIT]  = done_r;
      readByte[`ADC_CSR_SPEED_BIT] = speed_r;
      readByte[`ADC_CSR_ON_BIT]    = convOn_r;
      readByte[`ADC_CSR_CH_MSB:`ADC_CSR_CH_LSB] = channel_r;            // see R08
    end else if (selHigh) begin
      readByte = result_r[9:2];                                          // see R10
    end else if (selLow) begin
      readByte = {6'h00, result_r[1:0]};                                 // see R11
    end else if (selStat) begin
      readByte = {6'h00, evtStat_r};
    end else if (selMask) begin
      readByte = {6'h00, evtMask_r};
    end
  end

  // APB response; pready is a flip-flop, so every access has one wait state
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready_r      <= 1'b0;
      pslverr_r     <= 1'b0;
      prdata_r      <= 32'h00000000;
      capStat_r     <= 2'h0;
      freshResult_r <= 1'b0;
    end else begin
      if (apbFirst) begin
        pready_r      <= 1'b1;
        pslverr_r     <= ~mapped;                                        // see R12
        prdata_r      <= pwrite ? 32'h00000000 : {24'h000000, readByte};
        capStat_r     <= (selStat & ~pwrite) ? evtStat_r : 2'h0;
        freshResult_r <= 1'b0;
      end else if (apbDone) begin
        pready_r      <= 1'b0;
        pslverr_r     <= 1'b0;
        freshResult_r <= 1'b0;
      end else if (pready_r) begin
        // Master dropped the request; close the handshake
        pready_r      <= 1'b0;
        pslverr_r     <= 1'b0;
        freshResult_r <= 1'b0;
      end
      // Flag is set only by a result landing while a dropped access closes; the next access start clears it
      if (pready_r & finish & ~apbDone) begin
        freshResult_r <= 1'b1;
      end
    end
  end

  // Control/status and result registers
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      done_r    <= 1'b0;                                                 // see R13
      speed_r   <= 1'b0;
      convOn_r  <= 1'b0;
      channel_r <= 4'h0;
      result_r  <= `ADC_RESULT_RESET;
    end else begin
      done_r <= doneNxt;
      if (wrCsr) begin
        // Bit 4 is not stored and reads as zero
        speed_r   <= pwdata[`ADC_CSR_SPEED_BIT];
        convOn_r  <= pwdata[`ADC_CSR_ON_BIT];                            // see R06
        channel_r <= pwdata[`ADC_CSR_CH_MSB:`ADC_CSR_CH_LSB];
      end
      // Not double-buffered: a slow reader can see halves of two results
      if (finish) begin
        result_r <= codeKept;                                            // see R16, R19
      end
    end
  end

  // Event status, mask and interrupt line; the flag above never drives irq
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      evtStat_r <= `ADC_EVT_RESET;
      evtMask_r <= `ADC_EVT_RESET;
      irq_r     <= 1'b0;
    end else begin
      evtStat_r <= evtNxt;
      evtMask_r <= maskNxt;
      irq_r     <= |(evtNxt & maskNxt);                                  // see R18
    end
  end

  // Comparator from the analog core; only a value seen twice is believed
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmpS1_r     <= 1'b0;
      cmpS2_r     <= 1'b0;
      cmpS3_r     <= 1'b0;
      cmpStable_r <= 1'b0;
    end else begin
      cmpS1_r <= compareIn;
      cmpS2_r <= cmpS1_r;
      cmpS3_r <= cmpS2_r;
      if (cmpS2_r == cmpS3_r) begin
        cmpStable_r <= cmpS3_r;
      end
    end
  end

  // Trial bit is kept while the input stays above the trial level
  always @* begin
    codeKept = cmpStable_r ? code_r : (code_r & ~trialBit_r);            // see R17
  end

  // Sequencer next state; wait mode is not an input, so it changes nothing
  always @* begin
    state_nxt = state_r;                                                 // see R02
    case (state_r)
      ST_IDLE: begin
        if (runNxt) begin
          state_nxt = ST_SAMPLE;                                         // see R06
        end
      end
      ST_SAMPLE: begin
        if (tick && tickCnt_r == `ADC_SAMPLE_TICKS - 4'h1) begin
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (tick && tickCnt_r == `ADC_SETTLE_TICKS - 4'h1) begin
          state_nxt = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        if (tick) begin
          state_nxt = trialBit_r[0] ? ST_SAMPLE : ST_SETTLE;             // see R14
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (abortConv) begin
      state_nxt = runNxt ? ST_SAMPLE : ST_IDLE;                          // see R01, R15
    end
  end

  // Sequencer registers
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r    <= ST_IDLE;
      divCnt_r   <= 2'h0;
      tickCnt_r  <= 4'h0;
      trialBit_r <= `ADC_TRIAL_FIRST;
      code_r     <= 10'h000;
    end else begin
      state_r <= state_nxt;
      if (abortConv || state_nxt == ST_IDLE || tick) begin
        divCnt_r <= 2'h0;
      end else if (running) begin
        divCnt_r <= divCnt_r + 2'h1;
      end
      if (abortConv || state_nxt != state_r) begin
        tickCnt_r <= 4'h0;
      end else if (tick) begin
        tickCnt_r <= tickCnt_r + 4'h1;
      end
      if (abortConv || state_r == ST_IDLE || (state_r == ST_SAMPLE && tick)) begin
        trialBit_r <= `ADC_TRIAL_FIRST;
        code_r     <= `ADC_TRIAL_FIRST;
      end else if (state_r == ST_DECIDE && tick) begin
        // One of ten steps: settle the last decision, try the next bit
        trialBit_r <= {1'b0, trialBit_r[9:1]};                          // see R19
        code_r     <= codeKept | {1'b0, trialBit_r[9:1]};
      end
    end
  end

  // Analog-facing outputs, all registered
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sample_r    <= 1'b0;
      powerDown_r <= 1'b1;
      muxEn_r     <= 1'b0;
      chanOut_r   <= 4'h0;
    end else begin
      sample_r    <= (state_nxt == ST_SAMPLE);
      powerDown_r <= ~runNxt;                                            // see R01, R03
      chanOut_r   <= wrCsr ? pwdata[`ADC_CSR_CH_MSB:`ADC_CSR_CH_LSB] : channel_r;
      muxEn_r     <= runNxt & ({1'b0, (wrCsr ? pwdata[3:0] : channel_r)}
                              < `ADC_NUM_INPUTS);                        // see R09
    end
  end

  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign irq                = irq_r;
  assign channelSelect      = chanOut_r;
  assign muxEnable          = muxEn_r;
  assign sampleEnable       = sample_r;
  assign trialCode          = code_r;
  assign converterPowerDown = powerDown_r;

endmodule

// ### design/adc_defs.vh
`ifndef ADC_DEFS_VH
`define ADC_DEFS_VH
// Overview of operation
// R01: Clearing converter_on powers the converter down and stops any running conversion.
// R02: Wait mode has no effect; conversions and registers behave as in run mode.
// R03: Halt mode disables the converter; software waits stabilization_time after wake-up.
// R04: Done flag bit 7 set on completion; cleared by high read or control write.
// R05: Bit 6 picks conversion_clock: 0 gives cpu_clock/4, 1 gives cpu_clock/2.
// R06: Bit 5 written 1 enables and starts converting; written 0 disables and halts.
// R07: Software always writes zero to reserved bit 4 of the control register.
// R08: channel_select bits 3:0 route input of that index, 0 through 15.
// R09: Number of implemented inputs is a device constant; higher codes select nothing.
// R10: High result byte shows result bits 9 down to 2 in bits 7 to 0.
// R11: Low result byte shows result bits 1:0; bits 7:2 read zero.
// R12: Control, high and low registers sit at three consecutive addresses in order.
// R13: Reset clears all three registers: off, flag clear, channel 0, divide by 4.
// R14: Once enabled, conversions of the chosen channel repeat back to back.
// R15: Writing a new channel aborts, clears the flag and restarts on the new input.
// R16: Results are not latched; software reads low then high before next completion.
// R17: Over-range input gives all ones, under-range all zeros, no overflow flag.
// R18: The converter itself raises no request; completion shows in the polled flag. The code also drives irq from event status bits masked by evtMask_r.
// R19: Each conversion takes a fixed tick count: sampling plus ten approximation steps.

// Register indices; byte address is four times the index
`define ADC_IDX_CSR        10'h070
`define ADC_IDX_HIGH       10'h071
`define ADC_IDX_LOW        10'h072
`define ADC_IDX_EVT_STAT   10'h073
`define ADC_IDX_EVT_MASK   10'h074

// Control/status field positions
`define ADC_CSR_DONE_BIT   7
`define ADC_CSR_SPEED_BIT  6
`define ADC_CSR_ON_BIT     5
`define ADC_CSR_CH_MSB     3
`define ADC_CSR_CH_LSB     0

// Event status/mask field positions
`define ADC_EVT_DONE_BIT   0
`define ADC_EVT_OVR_BIT    1

// Reset values
`define ADC_CSR_RESET      8'h00
`define ADC_RESULT_RESET   10'h000
`define ADC_EVT_RESET      2'h0

// Implemented analog inputs (at most 16)
`define ADC_NUM_INPUTS     5'h10

// Timing: divider last counts in clock cycles, phase lengths in conversion_clock ticks
`define ADC_DIV4_LAST      2'h3
`define ADC_DIV2_LAST      2'h1
`define ADC_SAMPLE_TICKS   4'h4
`define ADC_SETTLE_TICKS   4'h3
`define ADC_TRIAL_FIRST    10'h200

// Sequencer states
`define ADC_ST_IDLE        2'h0
`define ADC_ST_SAMPLE      2'h1
`define ADC_ST_SETTLE      2'h2
`define ADC_ST_DECIDE      2'h3
`endif

// ### sim/adc_control_and_result_regs_sva.sv
`include "adc_defs.vh"
module adc_control_and_result_regs_sva (
  // System
  input logic        clock,
  input logic        nrst,
  input logic        haltMode,
  // APB
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0]  pstrb,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // Converter core
  input logic [3:0]  channelSelect,
  input logic        muxEnable,
  input logic        sampleEnable,
  input logic        converterPowerDown
);
  timeunit 1ns;
  timeprecision 1ns;
  wire xfer = psel && penable && pready;
  wire csrWr = xfer && pwrite && pstrb[0] && paddr[11:2] == `ADC_IDX_CSR;
  wire csrRd = xfer && !pwrite && paddr[11:2] == `ADC_IDX_CSR;
  wire lowRd = xfer && !pwrite && paddr[11:2] == `ADC_IDX_LOW;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("pready not in second access cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_low; lowRd |-> prdata[31:2] == 30'h0; endproperty
  a_low: assert property (p_low) else $error("low byte upper bits set");
  property p_rsv; csrRd |-> prdata[4] == 1'h0 && prdata[31:8] == 24'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved control bits set");
  property p_off; csrWr && !pwdata[5] |=> converterPowerDown && !sampleEnable; endproperty
  a_off: assert property (p_off) else $error("converter still on");
  property p_on; csrWr && pwdata[5] && converterPowerDown && !haltMode |=> sampleEnable; endproperty
  a_on: assert property (p_on) else $error("no start after enable");
  property p_halt; haltMode |=> converterPowerDown && !sampleEnable; endproperty
  a_halt: assert property (p_halt) else $error("converter runs in halt");
  property p_chan; csrWr |=> channelSelect == $past(pwdata[3:0]); endproperty
  a_chan: assert property (p_chan) else $error("channel not routed");
  property p_mux; muxEnable |-> !converterPowerDown; endproperty
  a_mux: assert property (p_mux) else $error("mux on while powered down");
  property p_restart;
    csrWr && pwdata[5] && !haltMode && pwdata[3:0] != channelSelect |=> sampleEnable;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on new channel");
endmodule

// ### sim/analog_core_model.sv
module analog_core_model (
  // System
  input  logic         clock,
  // Converter side
  input  logic [3:0]   channelSelect,
  input  logic         muxEnable,
  input  logic [9:0]   trialCode,
  input  logic         converterPowerDown,
  input  logic [159:0] levels,
  output logic         compareIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic noise_r = 1'h0;
  always @(posedge clock) noise_r <= ~noise_r;
  // Input equals its code, so a greater-or-equal compare settles on the code itself
  assign compareIn = (muxEnable && !converterPowerDown) ?
                     (levels[10*channelSelect +: 10] >= trialCode) : noise_r;
endmodule

// ### sim/adc_control_and_result_regs_test.sv
`include "adc_defs.vh"
module adc_control_and_result_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'h0, nrst = 1'h0, haltMode = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [159:0] levels = 160'h0;
  wire [31:0] prdata;
  wire [9:0] trialCode;
  wire [3:0] channelSelect;
  wire pready, pslverr, irq, compareIn, muxEnable, sampleEnable, converterPowerDown;
  int miscompares = 0, samplesChecked = 0, cyc = 0;
  always #50 clock = ~clock;
  adc_control_and_result_regs i_dut (.clock(clock), .nrst(nrst), .haltMode(haltMode),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .compareIn(compareIn), .channelSelect(channelSelect), .muxEnable(muxEnable),
    .sampleEnable(sampleEnable), .trialCode(trialCode),
    .converterPowerDown(converterPowerDown));
  analog_core_model i_core (.clock(clock), .channelSelect(channelSelect),
    .muxEnable(muxEnable), .trialCode(trialCode),
    .converterPowerDown(converterPowerDown), .levels(levels), .compareIn(compareIn));
  task automatic finishTest;
    if (miscompares == 0 && samplesChecked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      finishTest;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    pstrb <= 4'hF;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n >= 16) miscompares++;
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdChk(input logic [9:0] idx, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic e;
    apb(1'h0, idx, 8'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, idx, d, r, e);
  endtask
  task automatic csr(input logic sp, input logic on, input logic [3:0] ch);
    wr(`ADC_IDX_CSR, {1'h0, sp, on, 1'h0, ch});
  endtask
  task automatic waitDone;
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'h0, `ADC_IDX_CSR, 8'h0, r, e);
      n++;
    end while (r[7] !== 1'h1 && n < 100);
    if (n >= 100) miscompares++;
  endtask
  task automatic waitIrq(output int t);
    int n;
    n = 0;
    while (irq !== 1'h1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    t = cyc;
    if (n >= 400) miscompares++;
  endtask
  initial begin
    int t0, t1;
    logic [3:0] ch;
    logic sp;
    logic [9:0] v;
    logic [31:0] rr;
    logic ee;
    void'($urandom(32'h82DF));
    for (int i = 0; i < 16; i++) levels[10*i +: 10] = 10'($urandom);
    levels[9:0] = 10'h3FF;
    levels[159:150] = 10'h000;
    repeat (10) @(posedge clock);
    nrst <= 1'h1;
    for (int i = 0; i < 5; i++) rdChk(10'(`ADC_IDX_CSR + i), 32'h0, 1'h0);
    rdChk(10'h080, 32'h0, 1'h1);
    csr(1'h0, 1'h1, 4'h1);
    repeat (250) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    for (int k = 0; k < 6; k++) begin
      ch = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'($urandom);
      sp = 1'($urandom);
      v = levels[10*ch +: 10];
      // Switch off first so a repeated channel still starts a fresh conversion
      csr(sp, 1'h0, ch);
      csr(sp, 1'h1, ch);
      rdChk(`ADC_IDX_CSR, {24'h0, 1'h0, sp, 2'h2, ch}, 1'h0);
      waitDone;
      rdChk(`ADC_IDX_LOW, {30'h0, v[1:0]}, 1'h0);
      rdChk(`ADC_IDX_HIGH, {24'h0, v[9:2]}, 1'h0);
      rdChk(`ADC_IDX_CSR, {24'h0, 1'h0, sp, 2'h2, ch}, 1'h0);
    end
    wr(`ADC_IDX_EVT_MASK, 8'h01);
    for (int s = 0; s < 2; s++) begin
      // Status is read-to-clear: stop the converter, then drain stale events
      csr(1'(s), 1'h0, 4'h3);
      apb(1'h0, `ADC_IDX_EVT_STAT, 8'h0, rr, ee);
      rdChk(`ADC_IDX_EVT_STAT, 32'h0, 1'h0);
      csr(1'(s), 1'h1, 4'h3);
      repeat (2) @(posedge clock);
      waitIrq(t0);
      rdChk(`ADC_IDX_EVT_STAT, 32'h1, 1'h0);
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, 32'h0);
      waitIrq(t1);
      chk(t1 - t0, 176 >> s);
      rdChk(`ADC_IDX_EVT_STAT, 32'h3, 1'h0);
    end
    csr(1'h0, 1'h1, 4'h5);
    haltMode <= 1'h1;
    repeat (300) @(posedge clock);
    rdChk(`ADC_IDX_CSR, 32'h25, 1'h0);
    haltMode <= 1'h0;
    csr(1'h1, 1'h0, 4'h9);
    repeat (400) @(posedge clock);
    rdChk(`ADC_IDX_CSR, 32'h49, 1'h0);
    finishTest;
  end
endmodule
bind adc_control_and_result_regs adc_control_and_result_regs_sva i_sva (.clock(clock),
  .nrst(nrst), .haltMode(haltMode), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .channelSelect(channelSelect), .muxEnable(muxEnable),
  .sampleEnable(sampleEnable), .converterPowerDown(converterPowerDown));
